// ==== core/atac_defs.vh ====
// Constants for the block-mode and power-management command engine.
// Assumes one 40 MHz core clock and a host that presents task-file values with each command.
`ifndef ATAC_DEFS_VH
`define ATAC_DEFS_VH

// Command codes
`define ATAC_CMD_INIT_GEOM 8'h91
`define ATAC_CMD_RD_MULT 8'hC4
`define ATAC_CMD_WR_MULT 8'hC5
`define ATAC_CMD_SET_MULT 8'hC6
`define ATAC_CMD_STBY_IMM 8'hE0
`define ATAC_CMD_IDLE_IMM 8'hE1
`define ATAC_CMD_STBY_APD 8'hE2
`define ATAC_CMD_IDLE_APD 8'hE3
`define ATAC_CMD_RD_BUF 8'hE4
`define ATAC_CMD_CHK_PWR 8'hE5
`define ATAC_CMD_SLEEP 8'hE6
`define ATAC_CMD_WR_BUF 8'hE8

// Field positions
`define ATAC_DH_DRV_BIT 4
`define ATAC_DH_HEAD_MSB 3

// Check-power answers
`define ATAC_PWR_IDLE_VAL 8'hFF
`define ATAC_PWR_STBY_VAL 8'h00

// Reset values
`define ATAC_RST_BLK_CNT 8'h00
`define ATAC_RST_SPT 8'h00
`define ATAC_RST_HEADS 4'h0

// Timing
`define ATAC_CLK_HZ 40000000
`define ATAC_APD_UNIT_S 5
`define ATAC_APD_MIN 8'h0C
`define ATAC_SECT_WORDS 256
`define ATAC_MAX_BLOCK 16

`endif

// ==== core/atac_apd_timer.v ====
// Power-down countdown: a prescaler makes one tick per time unit, and a unit counter counts down.
// Assumes restart is a one-cycle pulse from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "atac_defs.vh"
module atac_apd_timer #(
  parameter integer TICK_CYCLES = `ATAC_APD_UNIT_S * `ATAC_CLK_HZ,
  parameter integer PRE_W = 28
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst_b,
  // Control
  input wire restart,
  input wire enable,
  input wire [7:0] reload,
  // Event
  output reg expire
);

  reg [PRE_W-1:0] pre_q;
  reg [7:0] units_q;
  wire tick;

  // Prescaler so each count unit equals one interval
  assign tick = (pre_q == TICK_CYCLES[PRE_W-1:0] - {{(PRE_W-1){1'b0}}, 1'b1});

  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pre_q <= {PRE_W{1'b0}};
      units_q <= 8'h00;
      expire <= 1'b0;
    end
    else
    begin
      expire <= 1'b0;
      if (restart || !enable)
      begin
        // Restart reloads from the count taken with the last standby or idle power-down command
        pre_q <= {PRE_W{1'b0}};
        units_q <= enable ? reload : 8'h00;
      end
      else if (units_q != 8'h00)
      begin
        if (tick)
        begin
          pre_q <= {PRE_W{1'b0}};
          units_q <= units_q - 8'h01;
          expire <= (units_q == 8'h01);
        end
        else
        begin
          pre_q <= pre_q + {{(PRE_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule
`default_nettype wire

// ==== core/atac_core.v ====
// Command engine for geometry setup, block-mode transfers, sector buffer access and power management.
// Assumes host and media logic run on sys_clk; strobes are one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
`include "atac_defs.vh"
module atac_core #(
  parameter integer TICK_CYCLES = `ATAC_APD_UNIT_S * `ATAC_CLK_HZ,
  parameter integer MAX_BLOCK = `ATAC_MAX_BLOCK,
  parameter integer ADDR_W = 12
) (
  // Clock and resets
  input wire sys_clk,
  input wire rst_b,
  input wire soft_rst,
  // Command
  input wire cmd_valid,
  input wire [7:0] cmd_code,
  input wire [7:0] cmd_sec_count,
  input wire [7:0] cmd_drv_head,
  input wire status_ack,
  // Status
  output reg bsy,
  output reg drq,
  output reg intrq,
  output reg err,
  output reg abrt,
  output reg sc_ret_valid,
  output reg [7:0] sc_ret_data,
  // Host data
  input wire host_rd,
  input wire host_wr,
  input wire [15:0] host_wdata,
  output wire [15:0] host_rdata,
  // Media
  output reg med_req,
  output reg med_write,
  output reg [8:0] med_sector,
  output reg [ADDR_W-1:0] med_buf_base,
  input wire med_buf_we,
  input wire [ADDR_W-1:0] med_buf_addr,
  input wire [15:0] med_buf_wdata,
  output wire [15:0] med_buf_rdata,
  input wire med_done,
  input wire med_err,
  // Configuration state
  output reg pwr_standby,
  output reg pwr_sleep,
  output reg apd_enabled,
  output reg apd_setting_standby,
  output reg block_mode_en,
  output reg [7:0] block_count,
  output reg [7:0] geom_spt0,
  output reg [3:0] geom_heads0,
  output reg [7:0] geom_spt1,
  output reg [3:0] geom_heads1
);

  localparam [6:0] S_IDLE = 7'h01;
  localparam [6:0] S_EXEC = 7'h02;
  localparam [6:0] S_RDM = 7'h04;
  localparam [6:0] S_RDX = 7'h08;
  localparam [6:0] S_WRX = 7'h10;
  localparam [6:0] S_WRM = 7'h20;
  localparam [6:0] S_BUF = 7'h40;

  reg [6:0] state_q;
  reg [7:0] cmd_q;
  reg [7:0] sc_q;
  reg [7:0] dh_q;
  reg [8:0] remain_q;
  reg [7:0] cur_q;
  reg [7:0] sec_in_q;
  reg [ADDR_W-1:0] ptr_q;
  reg blk_err_q;
  reg buf_wr_q;
  reg apd_restart_q;
  reg [7:0] apd_reload_q;
  reg [15:0] mem_q;
  reg [15:0] mem [0:(1<<ADDR_W)-1];
  wire apd_expire;
  wire [ADDR_W:0] blk_words;
  wire [15:0] blk_words_full;
  wire last_word;
  wire [8:0] remain_next;
  wire [7:0] sec_next;
  reg mem_we;
  reg [ADDR_W-1:0] mem_waddr;
  reg [15:0] mem_wdata;
  wire [ADDR_W-1:0] mem_raddr;

  // Sectors in the next block: full block, or the remainder at the end
  function [7:0] blk_size;
    input [8:0] remain;
    input [7:0] bc;
    begin
      blk_size = (remain >= {1'b0, bc}) ? bc : remain[7:0];
    end
  endfunction

  // Supported block counts: powers of two up to MAX_BLOCK
  function supported;
    input [7:0] bc;
    begin
      supported = (bc != 8'h00) && ((bc & (bc - 8'h01)) == 8'h00) && ({24'h000000, bc} <= MAX_BLOCK);
    end
  endfunction

  // Largest block is sixteen sectors, so the word count fits ADDR_W+1 bits
  assign blk_words_full = {cur_q, 8'h00};
  assign blk_words = blk_words_full[ADDR_W:0];
  assign last_word = ({1'b0, ptr_q} == blk_words - {{ADDR_W{1'b0}}, 1'b1});
  assign remain_next = remain_q - {1'b0, cur_q};
  assign sec_next = sec_in_q + 8'h01;
  assign mem_raddr = (state_q == S_WRM) ? med_buf_addr : ptr_q;
  assign host_rdata = mem_q;
  assign med_buf_rdata = mem_q;

  always @*
  begin
    mem_we = 1'b0;
    mem_waddr = ptr_q;
    mem_wdata = host_wdata;
    if (state_q == S_RDM)
    begin
      mem_we = med_buf_we;
      mem_waddr = med_buf_addr;
      mem_wdata = med_buf_wdata;
    end
    else if ((state_q == S_WRX) || ((state_q == S_BUF) && buf_wr_q))
    begin
      mem_we = host_wr;
    end
  end

  // Buffer shared by block transfers and buffer commands; first 256 words are the 512-byte region
  always @(posedge sys_clk)
  begin
    if (mem_we)
      mem[mem_waddr] <= mem_wdata;
    mem_q <= mem[mem_raddr];
  end

  atac_apd_timer #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_auto_power_down_counter (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .restart(apd_restart_q),
    .enable(apd_enabled),
    .reload(apd_reload_q),
    .expire(apd_expire)
  );

  task finish;
    input with_err;
    input with_abrt;
    begin
      err <= err | with_err;
      abrt <= with_abrt;
      intrq <= 1'b1;
      bsy <= 1'b0;
      drq <= 1'b0;
      state_q <= S_IDLE;
    end
  endtask

  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q <= S_IDLE;
      cmd_q <= 8'h00;
      sc_q <= 8'h00;
      dh_q <= 8'h00;
      remain_q <= 9'h000;
      cur_q <= 8'h00;
      sec_in_q <= 8'h00;
      ptr_q <= {ADDR_W{1'b0}};
      blk_err_q <= 1'b0;
      buf_wr_q <= 1'b0;
      apd_restart_q <= 1'b0;
      apd_reload_q <= 8'h00;
      bsy <= 1'b0;
      drq <= 1'b0;
      intrq <= 1'b0;
      err <= 1'b0;
      abrt <= 1'b0;
      sc_ret_valid <= 1'b0;
      sc_ret_data <= 8'h00;
      med_req <= 1'b0;
      med_write <= 1'b0;
      med_sector <= 9'h000;
      med_buf_base <= {ADDR_W{1'b0}};
      pwr_standby <= 1'b0;
      pwr_sleep <= 1'b0;
      apd_enabled <= 1'b0;
      apd_setting_standby <= 1'b0; // Idle setting by default
      block_mode_en <= 1'b0; // Block mode off after power-on
      block_count <= `ATAC_RST_BLK_CNT;
      geom_spt0 <= `ATAC_RST_SPT;
      geom_heads0 <= `ATAC_RST_HEADS;
      geom_spt1 <= `ATAC_RST_SPT;
      geom_heads1 <= `ATAC_RST_HEADS;
    end
    else
    begin
      med_req <= 1'b0;
      sc_ret_valid <= 1'b0;
      apd_restart_q <= 1'b0;
      // Acknowledge first so an interrupt raised in the same cycle wins
      if (status_ack)
        intrq <= 1'b0;
      // Expiry sends the drive to standby under either setting
      if (apd_expire)
        pwr_standby <= 1'b1;
      if (soft_rst)
      begin
        state_q <= S_IDLE;
        bsy <= 1'b0;
        drq <= 1'b0;
        block_mode_en <= 1'b0;
        block_count <= `ATAC_RST_BLK_CNT;
        if (pwr_sleep)
        begin
          // Reset is the only way out of sleep, and it lands in standby
          pwr_sleep <= 1'b0;
          pwr_standby <= 1'b1;
        end
      end
      else
      begin
        case (state_q)
          S_IDLE:
          begin
            if (cmd_valid)
            begin
              // Busy goes up the cycle after a command is taken
              cmd_q <= cmd_code;
              sc_q <= cmd_sec_count;
              dh_q <= cmd_drv_head;
              bsy <= 1'b1;
              err <= 1'b0;
              abrt <= 1'b0;
              state_q <= S_EXEC;
            end
          end
          S_EXEC:
          begin
            apd_restart_q <= (cmd_q != `ATAC_CMD_CHK_PWR);
            case (cmd_q)
              `ATAC_CMD_INIT_GEOM:
              begin
                // Values kept as given, no range
                if (dh_q[`ATAC_DH_DRV_BIT])
                begin
                  geom_spt1 <= sc_q;
                  geom_heads1 <= dh_q[`ATAC_DH_HEAD_MSB:0];
                end
                else
                begin
                  geom_spt0 <= sc_q;
                  geom_heads0 <= dh_q[`ATAC_DH_HEAD_MSB:0];
                end
                finish(1'b0, 1'b0);
              end
              `ATAC_CMD_SET_MULT:
              begin
                // Count was loaded by the host with the command
                if (sc_q == 8'h00)
                begin
                  block_mode_en <= 1'b0;
                  finish(1'b0, 1'b0);
                end
                else if (supported(sc_q))
                begin
                  block_count <= sc_q;
                  block_mode_en <= 1'b1;
                  finish(1'b0, 1'b0);
                end
                else
                begin
                  block_mode_en <= 1'b0;
                  finish(1'b1, 1'b1);
                end
              end
              `ATAC_CMD_RD_MULT, `ATAC_CMD_WR_MULT:
              begin
                if (!block_mode_en || pwr_sleep)
                begin
                  finish(1'b1, 1'b1);
                end
                else
                begin
                  pwr_standby <= 1'b0; // Media access spins the drive up
                  remain_q <= {(sc_q == 8'h00), sc_q};
                  cur_q <= blk_size({(sc_q == 8'h00), sc_q}, block_count);
                  sec_in_q <= 8'h00;
                  ptr_q <= {ADDR_W{1'b0}};
                  blk_err_q <= 1'b0;
                  med_sector <= 9'h000;
                  med_buf_base <= {ADDR_W{1'b0}};
                  if (cmd_q == `ATAC_CMD_RD_MULT)
                  begin
                    med_write <= 1'b0;
                    med_req <= 1'b1;
                    state_q <= S_RDM;
                  end
                  else
                  begin
                    // Long bit is not looked at; write opens with DRQ and interrupt
                    med_write <= 1'b1;
                    bsy <= 1'b0;
                    drq <= 1'b1;
                    intrq <= 1'b1;
                    state_q <= S_WRX;
                  end
                end
              end
              `ATAC_CMD_RD_BUF, `ATAC_CMD_WR_BUF:
              begin
                // Prepare the buffer, then DRQ, busy off, interrupt
                buf_wr_q <= (cmd_q == `ATAC_CMD_WR_BUF);
                ptr_q <= {ADDR_W{1'b0}};
                cur_q <= 8'h01;
                bsy <= 1'b0;
                drq <= 1'b1;
                intrq <= 1'b1;
                state_q <= S_BUF;
              end
              `ATAC_CMD_STBY_IMM:
              begin
                pwr_standby <= 1'b1;
                finish(1'b0, 1'b0);
              end
              `ATAC_CMD_IDLE_IMM:
              begin
                pwr_standby <= 1'b0;
                finish(1'b0, 1'b0);
              end
              `ATAC_CMD_STBY_APD, `ATAC_CMD_IDLE_APD:
              begin
                // Setting persists until the other of the two commands
                apd_setting_standby <= (cmd_q == `ATAC_CMD_STBY_APD);
                pwr_standby <= (cmd_q == `ATAC_CMD_STBY_APD);
                apd_enabled <= (sc_q != 8'h00);
                // Short counts are lifted to the twelve-unit floor
                apd_reload_q <= (sc_q < `ATAC_APD_MIN) ? `ATAC_APD_MIN : sc_q;
                finish(1'b0, 1'b0);
              end
              `ATAC_CMD_CHK_PWR:
              begin
                sc_ret_valid <= 1'b1;
                sc_ret_data <= pwr_standby ? `ATAC_PWR_STBY_VAL : `ATAC_PWR_IDLE_VAL;
                finish(1'b0, 1'b0);
              end
              `ATAC_CMD_SLEEP:
              begin
                pwr_sleep <= 1'b1;
                pwr_standby <= 1'b1;
                finish(1'b0, 1'b0);
              end
              default:
              begin
                finish(1'b1, 1'b1);
              end
            endcase
          end
          S_RDM:
          begin
            if (med_done)
            begin
              blk_err_q <= blk_err_q | med_err;
              sec_in_q <= sec_next;
              med_sector <= med_sector + 9'h001;
              if (sec_next == cur_q)
              begin
                // Whole block staged: one DRQ and interrupt, errors shown here
                err <= err | blk_err_q | med_err;
                ptr_q <= {ADDR_W{1'b0}};
                bsy <= 1'b0;
                drq <= 1'b1;
                intrq <= 1'b1;
                state_q <= S_RDX;
              end
              else
              begin
                med_buf_base <= {sec_next[ADDR_W-9:0], 8'h00};
                med_req <= 1'b1;
              end
            end
          end
          S_RDX:
          begin
            if (host_rd)
            begin
              ptr_q <= ptr_q + {{(ADDR_W-1){1'b0}}, 1'b1};
              if (last_word)
              begin
                drq <= 1'b0;
                remain_q <= remain_next;
                if (remain_next == 9'h000)
                begin
                  state_q <= S_IDLE;
                end
                else
                begin
                  // Corrupt data still moved; next block fetched without a host interrupt
                  bsy <= 1'b1;
                  cur_q <= blk_size(remain_next, block_count);
                  sec_in_q <= 8'h00;
                  blk_err_q <= 1'b0;
                  med_buf_base <= {ADDR_W{1'b0}};
                  med_req <= 1'b1;
                  state_q <= S_RDM;
                end
              end
            end
          end
          S_WRX:
          begin
            if (host_wr)
            begin
              ptr_q <= ptr_q + {{(ADDR_W-1){1'b0}}, 1'b1};
              if (last_word)
              begin
                drq <= 1'b0;
                bsy <= 1'b1;
                sec_in_q <= 8'h00;
                med_buf_base <= {ADDR_W{1'b0}};
                med_req <= 1'b1;
                state_q <= S_WRM;
              end
            end
          end
          S_WRM:
          begin
            if (med_done)
            begin
              if (med_err)
              begin
                // Stop at the failing sector, even mid-block
                finish(1'b1, 1'b0);
              end
              else
              begin
                sec_in_q <= sec_next;
                med_sector <= med_sector + 9'h001;
                if (sec_next == cur_q)
                begin
                  remain_q <= remain_next;
                  ptr_q <= {ADDR_W{1'b0}};
                  if (remain_next == 9'h000)
                  begin
                    finish(1'b0, 1'b0);
                  end
                  else
                  begin
                    cur_q <= blk_size(remain_next, block_count);
                    bsy <= 1'b0;
                    drq <= 1'b1;
                    intrq <= 1'b1;
                    state_q <= S_WRX;
                  end
                end
                else
                begin
                  med_buf_base <= {sec_next[ADDR_W-9:0], 8'h00};
                  med_req <= 1'b1;
                end
              end
            end
          end
          S_BUF:
          begin
            if (buf_wr_q ? host_wr : host_rd)
            begin
              ptr_q <= ptr_q + {{(ADDR_W-1){1'b0}}, 1'b1};
              if (last_word)
              begin
                drq <= 1'b0;
                state_q <= S_IDLE;
              end
            end
          end
          default:
          begin
            state_q <= S_IDLE;
          end
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// ==== tb/atac_core_assertions.sv ====
// Port checker for the command engine.
// Bound onto atac_core; one clock, asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
`include "atac_defs.vh"
module atac_chk (
  // Clock and resets
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic soft_rst,
  // Command
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic [7:0] cmd_sec_count,
  // Status
  input wire logic bsy,
  input wire logic drq,
  input wire logic intrq,
  input wire logic err,
  input wire logic abrt,
  input wire logic sc_ret_valid,
  input wire logic [7:0] sc_ret_data,
  // Mode
  input wire logic pwr_standby,
  input wire logic pwr_sleep,
  input wire logic block_mode_en,
  input wire logic [7:0] block_count
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  wire logic [7:0] c = cmd_sec_count;
  wire take = cmd_valid && !bsy && !drq && !soft_rst;
  wire cfg = take && cmd_code == `ATAC_CMD_SET_MULT;
  wire blk = take && (cmd_code == `ATAC_CMD_RD_MULT || cmd_code == `ATAC_CMD_WR_MULT);
  // Only powers of two up to 16 are kept as block sizes
  wire pow2 = c == 8'h01 || c == 8'h02 || c == 8'h04 || c == 8'h08 || c == 8'h10;
  sequence ok_end;
    !bsy && intrq && !abrt;
  endsequence
  sequence aborted;
    !bsy && intrq && err && abrt;
  endsequence
  busy_on_take_a: assert property (take |=> bsy)
    else $error("busy missing after command");
  geom_walk_a: assert property (take && cmd_code == `ATAC_CMD_INIT_GEOM |=> bsy ##1 ok_end)
    else $error("geometry walk wrong");
  cfg_good_a: assert property (cfg && pow2 |-> ##2 ok_end ##0 block_mode_en && block_count == $past(c, 2))
    else $error("block size not taken");
  cfg_bad_a: assert property (cfg && !pow2 && c != 8'h00 |-> ##2 aborted ##0 !block_mode_en)
    else $error("bad block size not refused");
  cfg_zero_a: assert property (cfg && c == 8'h00 |-> ##2 !block_mode_en && !abrt)
    else $error("zero block size wrong");
  blk_off_a: assert property (blk && !block_mode_en |-> ##2 aborted)
    else $error("block command not aborted");
  wr_start_a: assert property (blk && cmd_code == `ATAC_CMD_WR_MULT && block_mode_en && !pwr_sleep |-> ##2 drq && intrq && !bsy)
    else $error("block write start wrong");
  soft_off_a: assert property (soft_rst |=> !block_mode_en && !bsy && !drq)
    else $error("soft reset left block mode");
  pwr_check_a: assert property (take && cmd_code == `ATAC_CMD_CHK_PWR |-> ##2 sc_ret_valid && sc_ret_data == ($past(pwr_standby) ? 8'h00 : 8'hFF))
    else $error("power check answer wrong");
  stby_now_a: assert property (take && (cmd_code == `ATAC_CMD_STBY_IMM || cmd_code == `ATAC_CMD_STBY_APD) |-> ##[1:3] pwr_standby)
    else $error("standby not entered");
endmodule
bind atac_core atac_chk chk_u (.sys_clk, .rst_b, .soft_rst, .cmd_valid, .cmd_code, .cmd_sec_count, .bsy, .drq,
  .intrq, .err, .abrt, .sc_ret_valid, .sc_ret_data, .pwr_standby, .pwr_sleep, .block_mode_en, .block_count);
`default_nettype wire

// ==== tb/atac_media_model.sv ====
// Behavioural media side: fills or drains one sector per request.
// Assumes requests are one-cycle pulses on sys_clk; stall sets answer speed.
`timescale 1ns/1ps
`default_nettype none
module atac_media (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Requests
  input wire logic med_req,
  input wire logic med_write,
  input wire logic [8:0] med_sector,
  input wire logic [11:0] med_buf_base,
  // Test controls
  input wire logic [8:0] fail_sector,
  input wire logic [3:0] stall,
  // Answers
  output logic med_buf_we,
  output logic [11:0] med_buf_addr,
  output logic [15:0] med_buf_wdata,
  output logic med_done,
  output logic med_err
);
  logic [8:0] s;
  logic [11:0] b;
  logic w;
  initial
  begin
    med_buf_we = 1'b0;
    med_buf_addr = 12'h000;
    med_buf_wdata = 16'h0000;
    med_done = 1'b0;
    med_err = 1'b0;
    forever
    begin
      @(posedge sys_clk);
      if (rst_b && med_req)
      begin
        s = med_sector;
        b = med_buf_base;
        w = med_write;
        repeat (stall) @(posedge sys_clk);
        for (int i = 0; i < 256; i++)
        begin
          #1;
          med_buf_we = !w;
          med_buf_addr = b + 12'(i);
          med_buf_wdata = {s[7:0], 8'(i)};
          @(posedge sys_clk);
        end
        #1;
        med_buf_we = 1'b0;
        med_done = 1'b1;
        med_err = (s == fail_sector);
        @(posedge sys_clk);
        #1;
        med_done = 1'b0;
        med_err = 1'b0;
      end
      else
        // Stale data must not look valid while idle
        med_buf_wdata <= ~med_buf_wdata;
    end
  end
endmodule
`default_nettype wire

// ==== tb/atac_core_test.sv ====
// Self-checking bench for the command engine with a behavioural media side.
// Assumes a 40 MHz clock and a power-down unit shortened to 20 cycles.
`timescale 1ns/1ps
`default_nettype none
`include "atac_defs.vh"
module atac_core_test;
  localparam integer TICK = 20;
  logic sys_clk, rst_b, soft_rst, cmd_valid, status_ack, host_rd, host_wr, bsy, drq, intrq, err, abrt;
  logic sc_ret_valid, med_req, med_write, med_buf_we, med_done, med_err, pwr_standby, pwr_sleep;
  logic apd_enabled, apd_setting_standby, block_mode_en;
  logic [7:0] cmd_code, cmd_sec_count, cmd_drv_head, sc_ret_data, block_count, geom_spt0, geom_spt1;
  logic [3:0] geom_heads0, geom_heads1, stall;
  logic [15:0] host_wdata, host_rdata, med_buf_wdata, med_buf_rdata;
  logic [8:0] med_sector, fail_sector;
  logic [11:0] med_buf_base, med_buf_addr;
  int fails, cmp_count;
  atac_core #(.TICK_CYCLES(TICK)) dut_u (.sys_clk, .rst_b, .soft_rst, .cmd_valid, .cmd_code, .cmd_sec_count,
    .cmd_drv_head, .status_ack, .bsy, .drq, .intrq, .err, .abrt, .sc_ret_valid, .sc_ret_data, .host_rd, .host_wr,
    .host_wdata, .host_rdata, .med_req, .med_write, .med_sector, .med_buf_base, .med_buf_we, .med_buf_addr,
    .med_buf_wdata, .med_buf_rdata, .med_done, .med_err, .pwr_standby, .pwr_sleep, .apd_enabled,
    .apd_setting_standby, .block_mode_en, .block_count, .geom_spt0, .geom_heads0, .geom_spt1, .geom_heads1);
  atac_media med_u (.sys_clk, .rst_b, .med_req, .med_write, .med_sector, .med_buf_base, .fail_sector, .stall,
    .med_buf_we, .med_buf_addr, .med_buf_wdata, .med_done, .med_err);
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic stop_test;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wait_on(ref logic s, input logic v);
    int n;
    n = 0;
    while (s !== v && n < 4000)
    begin
      tick(1);
      n++;
    end
    if (s !== v)
    begin
      fails++;
      stop_test;
    end
  endtask
  task automatic cmd(input logic [7:0] code, input logic [7:0] sc, input logic [7:0] dh);
    wait_on(bsy, 1'b0);
    wait_on(drq, 1'b0);
    cmd_code = code;
    cmd_sec_count = sc;
    cmd_drv_head = dh;
    cmd_valid = 1'b1;
    tick(1);
    cmd_valid = 1'b0;
    tick(2);
  endtask
  task automatic ack;
    status_ack = 1'b1;
    tick(1);
    status_ack = 1'b0;
  endtask
  task automatic rd_block(input int n, input int k);
    for (int i = 0; i < n * 256; i++)
    begin
      tick(1);
      chk(host_rdata, {8'(k + i / 256), 8'(i)});
      host_rd = 1'b1;
      tick(1);
      host_rd = 1'b0;
    end
  endtask
  task automatic wr_block(input int n, input int k);
    host_wr = 1'b1;
    for (int i = 0; i < n * 256; i++)
    begin
      host_wdata = {8'(k + i / 256), 8'(i)};
      tick(1);
    end
    host_wr = 1'b0;
  endtask
  task automatic t_cfg;
    chk(block_mode_en, 0);
    cmd(`ATAC_CMD_RD_MULT, 8'h01, 8'h00);
    chk(abrt, 1);
    cmd(`ATAC_CMD_SET_MULT, 8'h03, 8'h00);
    chk(block_mode_en, 0);
    cmd(`ATAC_CMD_SET_MULT, 8'h10, 8'h00);
    chk(block_count, 16'h0010);
    cmd(`ATAC_CMD_SET_MULT, 8'h00, 8'h00);
    chk(block_mode_en, 0);
    ack;
    cmd(`ATAC_CMD_INIT_GEOM, 8'h11, 8'h15);
    chk({geom_spt1, geom_heads1, intrq}, 16'h0000 | {8'h11, 4'h5, 1'b1});
    cmd(`ATAC_CMD_INIT_GEOM, 8'hFF, 8'h0F);
    chk({geom_spt0, geom_heads0, err}, 16'h0000 | {8'hFF, 4'hF, 1'b0});
    $display("config test done");
  endtask
  task automatic t_xfer;
    stall = 4'h3;
    fail_sector = 9'h005;
    cmd(`ATAC_CMD_SET_MULT, 8'h04, 8'h00);
    cmd(`ATAC_CMD_RD_MULT, 8'h06, 8'h00);
    ack;
    wait_on(drq, 1'b1);
    chk({err, intrq}, 16'h0001);
    ack;
    rd_block(4, 0);
    wait_on(drq, 1'b1);
    chk(err, 1);
    rd_block(2, 4);
    tick(3);
    chk({bsy, drq}, 16'h0000);
    stall = 4'h0;
    fail_sector = 9'h001;
    cmd(`ATAC_CMD_WR_MULT, 8'h05, 8'h00);
    ack;
    wr_block(4, 0);
    wait_on(intrq, 1'b1);
    chk({bsy, drq, err}, 16'h0001);
    chk({med_write, med_sector}, 16'h0201);
    fail_sector = 9'h1FF;
    cmd(`ATAC_CMD_WR_MULT, 8'h02, 8'h00);
    ack;
    wr_block(2, 8'h30);
    wait_on(intrq, 1'b1);
    chk({bsy, drq, err}, 16'h0000);
    ack;
    chk(med_buf_rdata, 16'h3000);
    cmd(`ATAC_CMD_WR_BUF, 8'h00, 8'h00);
    chk({bsy, drq, intrq}, 16'h0003);
    wr_block(1, 8'h5A);
    ack;
    cmd(`ATAC_CMD_RD_BUF, 8'h00, 8'h00);
    chk({bsy, drq, intrq}, 16'h0003);
    rd_block(1, 8'h5A);
    $display("transfer test done");
  endtask
  task automatic t_pwr;
    cmd(`ATAC_CMD_STBY_IMM, 8'h00, 8'h00);
    cmd(`ATAC_CMD_CHK_PWR, 8'h00, 8'h00);
    chk(sc_ret_data, 16'h0000);
    cmd(`ATAC_CMD_IDLE_APD, 8'h05, 8'h00);
    chk({apd_enabled, apd_setting_standby, pwr_standby}, 16'h0004);
    tick(225);
    cmd(`ATAC_CMD_CHK_PWR, 8'h00, 8'h00);
    chk(sc_ret_data, 16'h00FF);
    tick(20);
    chk(pwr_standby, 1);
    cmd(`ATAC_CMD_RD_MULT, 8'h01, 8'h00);
    chk(pwr_standby, 0);
    wait_on(drq, 1'b1);
    rd_block(1, 0);
    cmd(`ATAC_CMD_IDLE_APD, 8'h00, 8'h00);
    chk(apd_enabled, 0);
    cmd(`ATAC_CMD_STBY_APD, 8'h0C, 8'h00);
    chk({apd_setting_standby, pwr_standby}, 16'h0003);
    cmd(`ATAC_CMD_SLEEP, 8'h00, 8'h00);
    cmd(`ATAC_CMD_RD_MULT, 8'h01, 8'h00);
    chk({pwr_sleep, abrt}, 16'h0003);
    soft_rst = 1'b1;
    tick(1);
    soft_rst = 1'b0;
    tick(1);
    chk({pwr_sleep, pwr_standby, block_mode_en}, 16'h0002);
    $display("power test done");
  endtask
  initial
  begin
    {rst_b, soft_rst, cmd_valid, status_ack, host_rd, host_wr} = 6'h00;
    {cmd_code, cmd_sec_count, cmd_drv_head, host_wdata} = 40'h0;
    fail_sector = 9'h1FF;
    stall = 4'h0;
    tick(20);
    rst_b = 1'b1;
    t_cfg;
    t_xfer;
    t_pwr;
    stop_test;
  end
endmodule
`default_nettype wire
